// *** dprc_pkg.sv ***
// Shared constants and types for the downstream port reset output controller
package dprc_pkg;

  // ============================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int MIN_ASSERT_US = 200;
  localparam int MIN_ASSERT_CYC = MIN_ASSERT_US * CLK_MHZ;
  localparam int DLY_UNIT_US = 1;
  localparam int DLY_UNIT_CYC = DLY_UNIT_US * CLK_MHZ;

  // ============================================================
  // Widths
  localparam int NPORT = 2;
  localparam int ADDR_W = 8;
  localparam int DLY_W = 8;
  localparam int MIN_CNT_W = 16;
  localparam int UNIT_CNT_W = 16;
  localparam int MODE_W = 2;
  localparam int STAT_PORT_W = 4;

  // ============================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] REG_HPCFG = 8'h00;
  localparam logic [ADDR_W-1:0] REG_SLOT_BASE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_SLOT_STRIDE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h0c;

  // ============================================================
  // Field positions and reset values
  localparam int MODE_LSB = 0;
  localparam int P2R_LSB = 8;
  localparam int R2P_LSB = 16;
  localparam int OE_LSB = 24;
  localparam int SLOT_PWROFF_BIT = 0;
  localparam int SLOT_SBR_BIT = 1;
  localparam logic [31:0] HPCFG_MASK = 32'h03ff_ff03;
  localparam logic [31:0] HPCFG_RST = 32'h0000_0000;
  localparam logic [1:0] SLOT_RST = 2'h1;

  // ============================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ============================================================
  // Modes and states
  typedef enum logic [MODE_W-1:0] {
    DPRC_MODE_PWREN,
    DPRC_MODE_PWRGD,
    DPRC_MODE_HOTRST,
    DPRC_MODE_RSVD
  } dprc_mode_t;

  typedef enum logic [1:0] {
    DPRC_ST_OFF,
    DPRC_ST_ON_WAIT,
    DPRC_ST_RUN,
    DPRC_ST_OFF_WAIT
  } dprc_state_t;

endpackage

// *** dprc_port_seq.sv ***
// Per-port reset output and slot power sequencer
`timescale 1ns/1ps
module dprc_port_seq #(
  parameter int MIN_CYC = dprc_pkg::MIN_ASSERT_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration
  input wire logic tick,
  input wire dprc_pkg::dprc_mode_t mode,
  input wire logic [dprc_pkg::DLY_W-1:0] p2r,
  input wire logic [dprc_pkg::DLY_W-1:0] r2p,
  // Slot control and status
  input wire logic power_off,
  input wire logic pwr_good,
  input wire logic trig,
  // Outputs
  output logic rst_n_out,
  output logic pep_out
);
  import dprc_pkg::*;

  localparam logic [MIN_CNT_W-1:0] MIN_LOAD = MIN_CNT_W'(MIN_CYC - 1);

  dprc_state_t st_reg, st_next;
  logic [DLY_W-1:0] dly_reg, dly_next;
  logic [MIN_CNT_W-1:0] min_reg, min_next;
  logic rst_n_reg, pep_reg;
  logic pg_mode, hot_mode, dly_done, min_done, want_rst, asrt_next;

  assign pg_mode = (mode == DPRC_MODE_PWRGD);
  assign hot_mode = (mode == DPRC_MODE_HOTRST);
  assign dly_done = (dly_reg == '0);
  assign min_done = (min_reg == '0);

  always_comb begin
    st_next = st_reg;
    dly_next = dly_reg;
    case (st_reg)
      DPRC_ST_OFF: begin
        if (!power_off) begin
          st_next = DPRC_ST_ON_WAIT;
          dly_next = p2r;
        end
      end
      DPRC_ST_ON_WAIT: begin
        if (power_off) begin
          st_next = DPRC_ST_OFF_WAIT;
          dly_next = r2p;
        end else if (pg_mode && !pwr_good) begin
          dly_next = p2r;
        end else if (dly_done && min_done) begin
          st_next = DPRC_ST_RUN;
        end else if (tick && !dly_done) begin
          dly_next = dly_reg - 8'h01;
        end
      end
      DPRC_ST_RUN: begin
        if (power_off) begin
          st_next = DPRC_ST_OFF_WAIT;
          dly_next = r2p;
        end else if (pg_mode && !pwr_good) begin
          st_next = DPRC_ST_ON_WAIT;
          dly_next = p2r;
        end
      end
      DPRC_ST_OFF_WAIT: begin
        if (dly_done) begin
          st_next = DPRC_ST_OFF;
        end else if (tick) begin
          dly_next = dly_reg - 8'h01;
        end
      end
      default: st_next = DPRC_ST_OFF;
    endcase
  end

  // Outside hot-reset mode the reset is wanted whenever the next state is not run; in hot-reset mode only while trig is high. The minimum hold overrides any release
  assign want_rst = hot_mode ? trig : (st_next != DPRC_ST_RUN);
  assign asrt_next = want_rst | (!rst_n_reg & !min_done);

  always_comb begin
    if (asrt_next && rst_n_reg) begin
      min_next = MIN_LOAD;
    end else if (!min_done) begin
      min_next = min_reg - MIN_CNT_W'(1);
    end else begin
      min_next = min_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= DPRC_ST_OFF;
      dly_reg <= '0;
      min_reg <= MIN_LOAD;
      rst_n_reg <= 1'h0;
      pep_reg <= 1'h0;
    end else begin
      st_reg <= st_next;
      dly_reg <= dly_next;
      min_reg <= min_next;
      rst_n_reg <= !asrt_next;
      pep_reg <= (st_next != DPRC_ST_OFF);
    end
  end

  assign rst_n_out = rst_n_reg;
  assign pep_out = pep_reg;
endmodule // dprc_port_seq

// *** dprc_slot_model.sv ***
// Slot power switch and endpoint model for the reset output controller bench
`timescale 1ns/1ps
module dprc_slot_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Controller pins
  input wire logic [1:0] pwr_en,
  input wire logic [1:0] rst_n,
  input wire logic [1:0] oe_n,
  // Bench control: ramp time and forced power fault
  input wire logic [7:0] ramp,
  input wire logic [1:0] fault,
  // Slot side
  output logic [1:0] pgood_n,
  output logic [1:0] dev_rst_n
);
  logic [7:0] cnt_reg [2];

  // ============================================================
  // Power ramp: good only after ramp cycles of steady enable
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 2; i++) begin
      if (!aresetn || !pwr_en[i] || fault[i]) begin
        cnt_reg[i] <= ramp;
        pgood_n[i] <= 1'b1;
      end else if (cnt_reg[i] != 8'h00) begin
        cnt_reg[i] <= cnt_reg[i] - 8'h01;
      end else begin
        pgood_n[i] <= 1'b0;
      end
    end
  end

  // Pull-down holds the endpoint in reset while the pin floats
  assign dev_rst_n = ~oe_n & rst_n;
endmodule // dprc_slot_model

// *** dprc_sync2.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dprc_sync2 #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] stage1_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end else begin
      stage1_reg <= d_in;
      q_reg <= stage1_reg;
    end
  end

  assign q_out = q_reg;
endmodule // dprc_sync2

// *** dprc_top.sv ***
// Downstream port reset output controller with AXI4-Lite register access
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps

// Overview of operation
// - Reset pins stay undriven until software enables them
// - Reset assertion lasts at least 200 us
// - Mode field picks power-enable, power-good or hot-reset
// - Power-enable mode: reset held while power off
// - Power-enable mode: reset negated while power on
// - Power-on write: enable power first, then release
// - Power-to-reset delay sets power-on release time
// - Power-off write: assert reset, then drop power
// - Reset-to-power delay sets power drop time
// - Power-good mode: release only after power good
// - Power-to-reset delay counts from power good
// - Power-good loss asserts reset at once
// - Hot mode: hot reset or bus resets assert reset
// - Hot mode: hold until cause ends and 200 us
// - Hot mode: secondary bus reset bit drives port reset
module dprc_top #(
  parameter int MIN_ASSERT_CYCLES = dprc_pkg::MIN_ASSERT_CYC,
  parameter int UNIT_CYCLES = dprc_pkg::DLY_UNIT_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [dprc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [dprc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Internal reset conditions
  input wire logic hot_reset_in,
  input wire logic upstream_sbr_in,
  // Slot pins
  input wire logic [dprc_pkg::NPORT-1:0] slot_power_good_n,
  output logic [dprc_pkg::NPORT-1:0] slot_power_enable_out,
  output logic [dprc_pkg::NPORT-1:0] port_reset_out_n,
  output logic [dprc_pkg::NPORT-1:0] port_reset_oe_n
);
  import dprc_pkg::*;

  // ============================================================
  // Registers and shared wires
  logic [31:0] hotplug_config_ctrl_reg;
  logic [1:0] slot_control_reg [NPORT];
  logic [NPORT-1:0] oe_n_reg;
  logic [UNIT_CNT_W-1:0] unit_cnt_reg;
  logic tick_reg;
  logic [NPORT-1:0] pg_n_sync;
  logic [NPORT-1:0] trig;
  logic [NPORT-1:0] wr_slot;
  logic [NPORT-1:0] rd_slot_hit;
  logic [31:0] rd_slot_part [NPORT];
  logic [31:0] stat_word;
  dprc_mode_t reset_output_mode_sel;
  logic [DLY_W-1:0] power_to_reset_delay;
  logic [DLY_W-1:0] reset_to_power_delay;

  assign reset_output_mode_sel =
    dprc_mode_t'(hotplug_config_ctrl_reg[MODE_LSB +: MODE_W]);
  assign power_to_reset_delay = hotplug_config_ctrl_reg[P2R_LSB +: DLY_W];
  assign reset_to_power_delay = hotplug_config_ctrl_reg[R2P_LSB +: DLY_W];

  // ============================================================
  // AXI4-Lite write channel
  logic awready_reg, wready_reg, bvalid_reg, aw_full_reg, w_full_reg;
  logic [1:0] bresp_reg;
  logic [ADDR_W-1:0] wa_reg;
  logic [31:0] wd_reg;
  logic [3:0] ws_reg;
  logic aw_take, w_take, aw_have, w_have, wr_go;
  logic aw_full_next, w_full_next, bvalid_next;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data, wr_mask, cfg_next;
  logic [3:0] wr_strb;
  logic wr_cfg, wr_stat, wr_hit;

  assign aw_take = s_axi_awvalid & awready_reg;
  assign w_take = s_axi_wvalid & wready_reg;
  assign aw_have = aw_full_reg | aw_take;
  assign w_have = w_full_reg | w_take;
  // Address and data may arrive in either order; commit once both are here
  assign wr_go = aw_have & w_have;
  assign aw_full_next = aw_have & !wr_go;
  assign w_full_next = w_have & !wr_go;
  assign bvalid_next = wr_go | (bvalid_reg & !s_axi_bready);
  assign wr_addr = aw_full_reg ? wa_reg : s_axi_awaddr;
  assign wr_data = w_full_reg ? wd_reg : s_axi_wdata;
  assign wr_strb = w_full_reg ? ws_reg : s_axi_wstrb;
  assign wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wr_cfg = wr_go & (wr_addr == REG_HPCFG);
  assign wr_stat = wr_go & (wr_addr == REG_STAT);
  assign wr_hit = wr_cfg | wr_stat | (|wr_slot);
  assign cfg_next = ((hotplug_config_ctrl_reg & ~wr_mask) | (wr_data & wr_mask)) & HPCFG_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'h0;
      wready_reg <= 1'h0;
      bvalid_reg <= 1'h0;
      bresp_reg <= RESP_OKAY;
      aw_full_reg <= 1'h0;
      w_full_reg <= 1'h0;
      wa_reg <= '0;
      wd_reg <= '0;
      ws_reg <= '0;
    end else begin
      awready_reg <= !aw_full_next & !bvalid_next;
      wready_reg <= !w_full_next & !bvalid_next;
      bvalid_reg <= bvalid_next;
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      if (aw_take) begin
        wa_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wd_reg <= s_axi_wdata;
        ws_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ============================================================
  // Configuration and slot control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hotplug_config_ctrl_reg <= HPCFG_RST;
      for (int i = 0; i < NPORT; i++) begin
        slot_control_reg[i] <= SLOT_RST;
      end
    end else begin
      if (wr_cfg) begin
        hotplug_config_ctrl_reg <= cfg_next;
      end
      for (int i = 0; i < NPORT; i++) begin
        // Secondary bus reset lasts until software writes the bit back to zero
        if (wr_slot[i] && wr_strb[0]) begin
          slot_control_reg[i] <= wr_data[1:0];
        end
      end
    end
  end

  // Pins come up as inputs; software must enable each before it drives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_n_reg <= '1;
    end else begin
      oe_n_reg <= ~hotplug_config_ctrl_reg[OE_LSB +: NPORT];
    end
  end

  // ============================================================
  // AXI4-Lite read channel
  logic arready_reg, rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic ar_take, rd_hit;
  logic [31:0] rd_mux, rd_slot_any;

  assign ar_take = s_axi_arvalid & arready_reg;

  always_comb begin
    rd_slot_any = 32'h0;
    for (int i = 0; i < NPORT; i++) begin
      rd_slot_any = rd_slot_any | rd_slot_part[i];
    end
  end

  assign rd_hit = (s_axi_araddr == REG_HPCFG) | (s_axi_araddr == REG_STAT) | (|rd_slot_hit);
  assign rd_mux = (s_axi_araddr == REG_HPCFG) ? hotplug_config_ctrl_reg :
                  (s_axi_araddr == REG_STAT) ? stat_word : rd_slot_any;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'h0;
      rvalid_reg <= 1'h0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'h0;
      rvalid_reg <= 1'h1;
      rdata_reg <= rd_hit ? rd_mux : 32'h0;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      arready_reg <= 1'h1;
      rvalid_reg <= 1'h0;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'h1;
    end
  end

  // ============================================================
  // Delay unit divider
  // One shared divider: a programmed delay of N is between N-1 and N units long
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_cnt_reg <= '0;
      tick_reg <= 1'h0;
    end else if (unit_cnt_reg == UNIT_CNT_W'(UNIT_CYCLES - 1)) begin
      unit_cnt_reg <= '0;
      tick_reg <= 1'h1;
    end else begin
      unit_cnt_reg <= unit_cnt_reg + UNIT_CNT_W'(1);
      tick_reg <= 1'h0;
    end
  end

  // ============================================================
  // Power good pin synchroniser
  dprc_sync2 #(
    .W(NPORT),
    .RST_VAL({NPORT{1'b1}})
  ) u_pg_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d_in(slot_power_good_n),
    .q_out(pg_n_sync)
  );

  // ============================================================
  // Per-port sequencers, decode and checks
  for (genvar g = 0; g < NPORT; g++) begin : g_port
    localparam logic [ADDR_W-1:0] SLOT_ADDR = REG_SLOT_BASE + REG_SLOT_STRIDE * ADDR_W'(g);
    logic [MIN_CNT_W-1:0] low_cnt_reg;

    assign wr_slot[g] = wr_go & (wr_addr == SLOT_ADDR);
    assign rd_slot_hit[g] = (s_axi_araddr == SLOT_ADDR);
    assign rd_slot_part[g] = rd_slot_hit[g] ? {30'h0, slot_control_reg[g]} : 32'h0;
    assign trig[g] = hot_reset_in | upstream_sbr_in |
                     slot_control_reg[g][SLOT_SBR_BIT];
    assign stat_word[g*STAT_PORT_W +: STAT_PORT_W] =
      {1'h0, !pg_n_sync[g], slot_power_enable_out[g], !port_reset_out_n[g]};

    dprc_port_seq #(
      .MIN_CYC(MIN_ASSERT_CYCLES)
    ) u_seq (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick_reg),
      .mode(reset_output_mode_sel),
      .p2r(power_to_reset_delay),
      .r2p(reset_to_power_delay),
      .power_off(slot_control_reg[g][SLOT_PWROFF_BIT]),
      .pwr_good(!pg_n_sync[g]),
      .trig(trig[g]),
      .rst_n_out(port_reset_out_n[g]),
      .pep_out(slot_power_enable_out[g])
    );

    // Cycles the reset has been low, saturating; read only by the checks
    always_ff @(posedge aclk) begin
      if (!aresetn || port_reset_out_n[g]) begin
        low_cnt_reg <= '0;
      end else if (low_cnt_reg != '1) begin
        low_cnt_reg <= low_cnt_reg + MIN_CNT_W'(1);
      end
    end

    property p_oe_gated;
      @(posedge aclk) disable iff (!aresetn)
      !port_reset_oe_n[g] |-> $past(hotplug_config_ctrl_reg[OE_LSB + g]);
    endproperty
    a_oe_gated: assert property (p_oe_gated)
      else $error("reset pin driven without enable");

    property p_min_width;
      @(posedge aclk) disable iff (!aresetn)
      $rose(port_reset_out_n[g]) |-> $past(low_cnt_reg) >= MIN_CNT_W'(MIN_ASSERT_CYCLES - 1);
    endproperty
    a_min_width: assert property (p_min_width)
      else $error("reset pulse shorter than minimum");

    property p_off_holds;
      @(posedge aclk) disable iff (!aresetn)
      (reset_output_mode_sel == DPRC_MODE_PWREN) && $stable(reset_output_mode_sel)
        && !slot_power_enable_out[g] |-> !port_reset_out_n[g];
    endproperty
    a_off_holds: assert property (p_off_holds)
      else $error("reset negated while slot power off");

    property p_release_powered;
      @(posedge aclk) disable iff (!aresetn)
      (reset_output_mode_sel != DPRC_MODE_HOTRST) && $rose(port_reset_out_n[g])
        |-> slot_power_enable_out[g] && $past(slot_power_enable_out[g]);
    endproperty
    a_release_powered: assert property (p_release_powered)
      else $error("reset released without slot power");

    property p_power_first;
      @(posedge aclk) disable iff (!aresetn)
      (reset_output_mode_sel != DPRC_MODE_HOTRST) && $rose(slot_power_enable_out[g])
        |-> !port_reset_out_n[g] && $past(!port_reset_out_n[g]);
    endproperty
    a_power_first: assert property (p_power_first)
      else $error("reset not held across power enable");

    property p_reset_before_off;
      @(posedge aclk) disable iff (!aresetn)
      (reset_output_mode_sel != DPRC_MODE_HOTRST) && $fell(slot_power_enable_out[g])
        |-> !port_reset_out_n[g] && !$past(port_reset_out_n[g]);
    endproperty
    a_reset_before_off: assert property (p_reset_before_off)
      else $error("power dropped before reset asserted");

    property p_pg_release;
      @(posedge aclk) disable iff (!aresetn)
      (reset_output_mode_sel == DPRC_MODE_PWRGD) && $rose(port_reset_out_n[g])
        |-> $past(!pg_n_sync[g]);
    endproperty
    a_pg_release: assert property (p_pg_release)
      else $error("reset released without power good");

    property p_pg_loss;
      @(posedge aclk) disable iff (!aresetn)
      (reset_output_mode_sel == DPRC_MODE_PWRGD) && port_reset_out_n[g] && pg_n_sync[g]
        |=> !port_reset_out_n[g];
    endproperty
    a_pg_loss: assert property (p_pg_loss)
      else $error("reset not asserted on power good loss");

    property p_hot_assert;
      @(posedge aclk) disable iff (!aresetn)
      (reset_output_mode_sel == DPRC_MODE_HOTRST) && trig[g] |=> !port_reset_out_n[g];
    endproperty
    a_hot_assert: assert property (p_hot_assert)
      else $error("reset not asserted on hot reset cause");

    property p_hot_hold;
      @(posedge aclk) disable iff (!aresetn)
      (reset_output_mode_sel == DPRC_MODE_HOTRST) && $rose(port_reset_out_n[g])
        |-> $past(!trig[g]) && $past(low_cnt_reg) >= MIN_CNT_W'(MIN_ASSERT_CYCLES - 1);
    endproperty
    a_hot_hold: assert property (p_hot_hold)
      else $error("hot reset released too early");
  end

  assign stat_word[31:NPORT*STAT_PORT_W] = '0;

  // ============================================================
  // Output drive
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign port_reset_oe_n = oe_n_reg;
endmodule // dprc_top

// *** tb.sv ***
// Self-checking bench for the downstream port reset output controller
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD %0t got %0h exp %0h", $time, a, e); end end
module tb;
  import dprc_pkg::*;
  localparam int MINC = 20;
  localparam int U = 4;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0, ramp = 8, p2r = 0, r2p = 0;
  logic [31:0] wdata = 0, rdata;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, hot = 0, up = 0;
  logic awr, wr, bv, arr, rv;
  logic [1:0] bresp, rresp, pgn, pep, rst_n, oe_n, dev_n, fault = 0;
  int bad_count = 0, num_checks = 0, lowc[2] = '{0, 0};

  dprc_top #(.MIN_ASSERT_CYCLES(MINC), .UNIT_CYCLES(U)) dprc_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .hot_reset_in(hot),
    .upstream_sbr_in(up), .slot_power_good_n(pgn), .slot_power_enable_out(pep),
    .port_reset_out_n(rst_n), .port_reset_oe_n(oe_n));
  dprc_slot_model dprc_slot_model_inst (.aclk(aclk), .aresetn(aresetn), .pwr_en(pep),
    .rst_n(rst_n), .oe_n(oe_n), .ramp(ramp), .fault(fault), .pgood_n(pgn), .dev_rst_n(dev_n));

  initial begin
    forever #5 aclk = ~aclk;
  end

  // ============================================================
  // Minimum low time on every reset pulse, in every mode
  always @(posedge aclk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_n[i] === 1'b1) begin
        if (lowc[i] != 0) `CHK(lowc[i] >= MINC, 1'b1)
        lowc[i] = 0;
      end else lowc[i]++;
    end
  end

  // ============================================================
  // Bus and wait helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 2000) begin
      bad_count++;
      report_and_stop();
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (awv && awr) awv <= 0;
      if (wv && wr) wv <= 0;
    end while (!(bv && bready) && n < 2000);
    bready <= 0;
    tmo(n);
    `CHK(bresp, er)
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (arv && arr) arv <= 0;
    end while (!(rv && rready) && n < 2000);
    rready <= 0;
    d = rdata;
    tmo(n);
    `CHK(rresp, er)
  endtask

  task automatic wsig(input bit s, input int p, input logic v, output int n);
    n = 0;
    while (((s ? pep[p] : rst_n[p]) !== v) && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    tmo(n);
  endtask

  // Window of a delay of n ticks, with slack for bus and sampling skew
  function automatic int dlo(int n);
    return (n == 0) ? 0 : (n - 1) * U - 2;
  endfunction
  function automatic int dhi(int n);
    return n * U + 4;
  endfunction

  // ============================================================
  // Scenario steps
  task automatic cfg(input logic [1:0] m);
    logic [31:0] d, q;
    d = ($urandom() & ~HPCFG_MASK) | {6'h0, 2'b11, r2p, p2r, 6'h0, m};
    axw(REG_HPCFG, d, RESP_OKAY);
    axr(REG_HPCFG, q, RESP_OKAY);
    `CHK(q, d & HPCFG_MASK)
  endtask

  task automatic pwr_on(input int p, input int pg);
    int n;
    // Let the minimum hold run out so the window measures only the programmed delay
    repeat (MINC) @(posedge aclk);
    axw(8'h04 + 8'(4 * p), 32'h0, RESP_OKAY);
    wsig(1, p, 1, n);
    `CHK(rst_n[p], 1'b0)
    n = 0;
    while (pg != 0 && pgn[p] !== 1'b0 && n < 2000) begin
      @(posedge aclk);
      n++;
      `CHK(rst_n[p], 1'b0)
    end
    wsig(0, p, 1, n);
    `CHK(n >= dlo(p2r) + 2 * pg && n <= dhi(p2r) + 2 * pg, 1'b1)
    repeat (30) begin
      @(posedge aclk);
      `CHK(rst_n[p], 1'b1)
    end
  endtask

  task automatic pwr_off(input int p);
    int n;
    axw(8'h04 + 8'(4 * p), 32'h1, RESP_OKAY);
    wsig(0, p, 0, n);
    `CHK(pep[p], 1'b1)
    wsig(1, p, 0, n);
    `CHK(n >= dlo(r2p) && n <= dhi(r2p), 1'b1)
    repeat (30) begin
      @(posedge aclk);
      `CHK(rst_n[p], 1'b0)
    end
  endtask

  task automatic trig(input int k, input logic v);
    @(posedge aclk);
    if (k == 0) hot <= v;
    else if (k == 1) up <= v;
    else axw(8'h04, {30'h0, v, 1'b0}, RESP_OKAY);
  endtask

  // ============================================================
  // Main sequence
  initial begin
    logic [31:0] d;
    int n, len;
    void'($urandom(72));
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    `CHK(oe_n, 2'b11)
    `CHK(dev_n, 2'b00)
    axr(REG_HPCFG, d, RESP_OKAY);
    `CHK(d, HPCFG_RST)
    axr(8'h08, d, RESP_OKAY);
    `CHK(d, 32'h1)
    axr(8'h10, d, RESP_SLVERR);
    `CHK(d, 32'h0)
    axw(8'h10, 32'hffff_ffff, RESP_SLVERR);
    axw(REG_STAT, 32'h0, RESP_OKAY);
    for (int r = 0; r < 3; r++) begin
      p2r = 8'($urandom_range(0, 8));
      r2p = 8'($urandom_range(0, 8));
      ramp <= 8'($urandom_range(1, 40));
      // Mode 3 behaves as power-enable
      cfg((r == 2) ? 2'h3 : 2'h0);
      repeat (3) @(posedge aclk);
      `CHK(oe_n, 2'b00)
      pwr_on(0, 0);
      pwr_off(0);
      axr(REG_STAT, d, RESP_OKAY);
      `CHK(d, 32'h11)
      cfg(2'h1);
      pwr_on(1, 1);
      @(posedge aclk);
      fault[1] <= 1'b1;
      wsig(0, 1, 0, n);
      `CHK(n <= 6, 1'b1)
      fault[1] <= 1'b0;
      wsig(0, 1, 1, n);
      pwr_off(1);
      cfg(2'h2);
      axw(8'h04, 32'h0, RESP_OKAY);
      wsig(0, 0, 1, n);
      for (int k = 0; k < 3; k++) begin
        len = $urandom_range(1, 40);
        trig(k, 1'b1);
        wsig(0, 0, 0, n);
        `CHK(n <= 4, 1'b1)
        repeat (len) @(posedge aclk);
        trig(k, 1'b0);
        wsig(0, 0, 1, n);
        `CHK(n >= 1 && len + n <= ((len > MINC) ? len : MINC) + 10, 1'b1)
      end
      axw(8'h04, 32'h1, RESP_OKAY);
      wsig(1, 0, 0, n);
    end
    report_and_stop();
  end
endmodule // tb
